// ===== src/queue_filter_consts.vh
// register map, field positions, reset values and polynomial for the queue and filter block
`ifndef QUEUE_FILTER_CONSTS_VH
`define QUEUE_FILTER_CONSTS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_RX_FRAME_COUNT_THRESHOLD 10'h09c
`define IDX_TX_NEXT_SPACE_REQUEST 10'h09e
`define IDX_MULTICAST_HASH_WORD0 10'h0a0
`define IDX_MULTICAST_HASH_WORD1 10'h0a2
`define IDX_MULTICAST_HASH_WORD2 10'h0a4
`define IDX_MULTICAST_HASH_WORD3 10'h0a6
`define IDX_QUEUE_FILTER_CONTROL 10'h080
`define IDX_IRQ_STATUS 10'h081
`define IDX_IRQ_ENABLE 10'h082
`define IDX_IRQ_CLEAR 10'h083

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FRAME_COUNT_LIMIT_LSB 0
`define QUEUED_FRAME_COUNT_LSB 8
`define CTL_THRESHOLD_ENABLE 0
`define CTL_TX_SPACE_MONITOR 1
`define CTL_HASH_PERFECT_MODE 2
`define CTL_ACCEPT_ALL_FRAMES 3
`define CTL_ACCEPT_ALL_MULTICAST 4
`define IRQ_RECEIVE_BIT 0
`define IRQ_TX_SPACE_BIT 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_FRAME_COUNT_LIMIT 8'h00
`define RST_NEXT_TX_SPACE 16'h0000
`define RST_HASH_WORD 16'h0000
`define RST_CONTROL 5'h00
`define RST_IRQ 2'h0

// ----------------------------------------------------------------------
// hash crc
// ----------------------------------------------------------------------
`define CRC32_POLY 32'h04c11db7
`define CRC32_INIT 32'hffffffff
`define DA_BYTES 3'h6

`endif

// ===== src/da_hash_unit.v
// crc based hash index of a received destination address, one byte per cycle
`default_nettype none
`include "queue_filter_consts.vh"

module da_hash_unit (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_da_valid,
    input wire i_da_first,
    input wire [7:0] i_da_byte,
    output reg o_hash_valid,
    output reg [5:0] o_hash_index,
    output reg o_da_multicast
);

    reg [31:0] crc_ff;
    reg [2:0] byte_cnt_ff;
    reg group_ff;
    wire [31:0] crc_base;
    wire [31:0] crc_new;
    wire [2:0] cnt_base;

    // ------------------------------------------------------------------
    // crc step
    // ------------------------------------------------------------------
    // ethernet fcs polynomial, bits taken lsb first as on the wire
    function [31:0] crc_byte;
        input [31:0] crc_in;
        input [7:0] data;
        integer i;
        reg [31:0] c;
        reg fb;
        begin
            c = crc_in;
            for (i = 0; i < 8; i = i + 1) begin
                fb = c[31] ^ data[i];
                c = {c[30:0], 1'b0} ^ (fb ? `CRC32_POLY : 32'h00000000);
            end
            crc_byte = c;
        end
    endfunction

    // a first byte restarts the address, so a truncated one cannot poison the next
    assign crc_base = i_da_first ? `CRC32_INIT : crc_ff;
    assign cnt_base = i_da_first ? 3'h0 : byte_cnt_ff;
    // [RL15] standard fcs crc
    assign crc_new = crc_byte(crc_base, i_da_byte);

    // ------------------------------------------------------------------
    // accumulate six bytes
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            crc_ff <= `CRC32_INIT;
            byte_cnt_ff <= 3'h0;
            group_ff <= 1'b0;
            o_hash_valid <= 1'b0;
            o_hash_index <= 6'h00;
            o_da_multicast <= 1'b0;
        end else if (i_ce) begin
            o_hash_valid <= 1'b0;
            if (i_da_valid && cnt_base < `DA_BYTES) begin
                crc_ff <= crc_new;
                byte_cnt_ff <= cnt_base + 3'h1;
                // group bit is the first bit sent of the first byte
                if (i_da_first) begin
                    group_ff <= i_da_byte[0];
                end
                // [RL8] top six crc bits
                if (cnt_base == `DA_BYTES - 3'h1) begin
                    o_hash_valid <= 1'b1;
                    o_hash_index <= crc_new[31:26];
                    o_da_multicast <= i_da_first ? i_da_byte[0] : group_ff;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== src/queue_threshold_and_multicast_hash.v
// queue frame count threshold, tx space request and multicast hash filter with apb registers
// Function
// [RL1] read-only frame count, caught at receive irq
// [RL2] host reads count before next headers
// [RL3] writable frame count threshold, resets zero
// [RL4] threshold enabled: irq when count exceeds
// [RL5] host writes needed tx double words
// [RL6] monitor enabled: irq when space suffices
// [RL7] four-word 64-bit table in hash mode
// [RL8] index is top six crc bits
// [RL9] two bits word, four bits bit
// [RL10] set table bit accepts frame
// [RL11] clear table bit drops frame
// [RL12] accept-all or all-multicast bypass table
// [RL13] receive flag on ready frame, w1c
// [RL14] tx space flag on availability, w1c
// [RL15] hash crc is ethernet fcs polynomial
`default_nettype none
`include "queue_filter_consts.vh"

module queue_threshold_and_multicast_hash #(
    parameter COUNT_W = 8,
    parameter SPACE_W = 16
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // receive queue events
    input wire i_rx_frame_done,
    input wire i_rx_frame_taken,
    // transmit queue free space in double words
    input wire [SPACE_W-1:0] i_tx_free_dw,
    // destination address bytes of a received frame
    input wire i_da_valid,
    input wire i_da_first,
    input wire [7:0] i_da_byte,
    output reg o_filter_valid,
    output reg o_filter_pass,
    output reg o_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [COUNT_W-1:0] frames_held_ff;
    reg [COUNT_W-1:0] queued_frame_count_ff;
    reg [COUNT_W-1:0] frame_count_limit_ff;
    reg [SPACE_W-1:0] next_tx_space_needed_ff;
    reg [15:0] hash_bits_ff [0:3];
    reg [4:0] control_ff;
    reg [1:0] irq_status_ff;
    reg [1:0] irq_enable_ff;
    reg space_met_ff;
    reg [COUNT_W-1:0] nxt_frames_held;
    reg [1:0] nxt_irq_status;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    reg nxt_rx_event;
    reg space_met_now;
    reg tx_event;
    reg [1:0] clear_bits;

    wire hash_valid;
    wire [5:0] hash_index;
    wire da_multicast;
    wire [9:0] reg_idx;
    wire byte_ok;
    wire access;
    wire write_done;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function reg_mapped;
        input [9:0] idx;
        begin
            case (idx)
                `IDX_RX_FRAME_COUNT_THRESHOLD,
                `IDX_TX_NEXT_SPACE_REQUEST,
                `IDX_MULTICAST_HASH_WORD0,
                `IDX_MULTICAST_HASH_WORD1,
                `IDX_MULTICAST_HASH_WORD2,
                `IDX_MULTICAST_HASH_WORD3,
                `IDX_QUEUE_FILTER_CONTROL,
                `IDX_IRQ_STATUS,
                `IDX_IRQ_ENABLE,
                `IDX_IRQ_CLEAR: reg_mapped = 1'b1;
                default: reg_mapped = 1'b0;
            endcase
        end
    endfunction

    // word aligned only; low address bits select nothing
    assign reg_idx = i_paddr[11:2];
    assign byte_ok = (i_paddr[1:0] == 2'b00) && reg_mapped(reg_idx);
    // first access cycle: one wait state before the answer
    assign access = i_psel && i_penable && !o_pready;
    // a write lands on the edge that samples pready high
    assign write_done = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

    // ------------------------------------------------------------------
    // hash unit
    // ------------------------------------------------------------------
    da_hash_unit u_hash (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_da_valid(i_da_valid),
        .i_da_first(i_da_first),
        .i_da_byte(i_da_byte),
        .o_hash_valid(hash_valid),
        .o_hash_index(hash_index),
        .o_da_multicast(da_multicast)
    );

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // clear register is write-only and reads zero
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = !byte_ok;
        case (reg_idx)
            // [RL1] count beside limit
            `IDX_RX_FRAME_COUNT_THRESHOLD: begin
                nxt_rdata[15:0] = {queued_frame_count_ff, frame_count_limit_ff};
            end
            `IDX_TX_NEXT_SPACE_REQUEST: nxt_rdata[15:0] = next_tx_space_needed_ff;
            `IDX_MULTICAST_HASH_WORD0: nxt_rdata[15:0] = hash_bits_ff[0];
            `IDX_MULTICAST_HASH_WORD1: nxt_rdata[15:0] = hash_bits_ff[1];
            `IDX_MULTICAST_HASH_WORD2: nxt_rdata[15:0] = hash_bits_ff[2];
            `IDX_MULTICAST_HASH_WORD3: nxt_rdata[15:0] = hash_bits_ff[3];
            `IDX_QUEUE_FILTER_CONTROL: nxt_rdata[4:0] = control_ff;
            `IDX_IRQ_STATUS: nxt_rdata[1:0] = irq_status_ff;
            `IDX_IRQ_ENABLE: nxt_rdata[1:0] = irq_enable_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            if (access) begin
                o_pready <= 1'b1;
                o_pslverr <= nxt_err;
                // a refused read answers zero, never the register the low bits alias
                o_prdata <= (i_pwrite || nxt_err) ? 32'h00000000 : nxt_rdata;
            end else begin
                o_pready <= 1'b0;
                o_pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // frame accounting and event detection
    // ------------------------------------------------------------------
    always @* begin
        nxt_frames_held = frames_held_ff;
        // saturate rather than wrap, a wrapped count would fire false irqs
        if (i_rx_frame_done && !i_rx_frame_taken && frames_held_ff != {COUNT_W{1'b1}}) begin
            nxt_frames_held = frames_held_ff + 1'b1;
        end else if (!i_rx_frame_done && i_rx_frame_taken && frames_held_ff != 0) begin
            nxt_frames_held = frames_held_ff - 1'b1;
        end
        // [RL4] exceeds limit when enabled
        if (control_ff[`CTL_THRESHOLD_ENABLE]) begin
            nxt_rx_event = i_rx_frame_done && (nxt_frames_held > frame_count_limit_ff);
        end else begin
            // [RL13] any complete frame
            nxt_rx_event = i_rx_frame_done;
        end
        // [RL6] free space covers request
        space_met_now = control_ff[`CTL_TX_SPACE_MONITOR] &&
            (i_tx_free_dw >= next_tx_space_needed_ff);
        tx_event = space_met_now && !space_met_ff;
        clear_bits = 2'b00;
        if (write_done && reg_idx == `IDX_IRQ_CLEAR) begin
            clear_bits = i_pwdata[1:0];
        end
        // [RL13] set wins over clear
        nxt_irq_status = irq_status_ff & ~clear_bits;
        if (nxt_rx_event) begin
            nxt_irq_status[`IRQ_RECEIVE_BIT] = 1'b1;
        end
        // [RL14] set wins over clear
        if (tx_event) begin
            nxt_irq_status[`IRQ_TX_SPACE_BIT] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // registers, status and interrupt
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            frames_held_ff <= {COUNT_W{1'b0}};
            queued_frame_count_ff <= {COUNT_W{1'b0}};
            // [RL3] limit resets to zero
            frame_count_limit_ff <= `RST_FRAME_COUNT_LIMIT;
            next_tx_space_needed_ff <= `RST_NEXT_TX_SPACE;
            hash_bits_ff[0] <= `RST_HASH_WORD;
            hash_bits_ff[1] <= `RST_HASH_WORD;
            hash_bits_ff[2] <= `RST_HASH_WORD;
            hash_bits_ff[3] <= `RST_HASH_WORD;
            control_ff <= `RST_CONTROL;
            irq_status_ff <= `RST_IRQ;
            irq_enable_ff <= `RST_IRQ;
            space_met_ff <= 1'b0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            frames_held_ff <= nxt_frames_held;
            space_met_ff <= space_met_now;
            irq_status_ff <= nxt_irq_status;
            o_irq <= |(nxt_irq_status & irq_enable_ff);
            // [RL1] snapshot on receive irq
            if (nxt_rx_event) begin
                queued_frame_count_ff <= nxt_frames_held;
            end
            if (write_done) begin
                case (reg_idx)
                    // [RL3] limit low byte only
                    `IDX_RX_FRAME_COUNT_THRESHOLD: begin
                        frame_count_limit_ff <= i_pwdata[COUNT_W-1:0];
                    end
                    // [RL5] host space request
                    `IDX_TX_NEXT_SPACE_REQUEST: begin
                        next_tx_space_needed_ff <= i_pwdata[SPACE_W-1:0];
                    end
                    // [RL7] table words
                    `IDX_MULTICAST_HASH_WORD0: hash_bits_ff[0] <= i_pwdata[15:0];
                    `IDX_MULTICAST_HASH_WORD1: hash_bits_ff[1] <= i_pwdata[15:0];
                    `IDX_MULTICAST_HASH_WORD2: hash_bits_ff[2] <= i_pwdata[15:0];
                    `IDX_MULTICAST_HASH_WORD3: hash_bits_ff[3] <= i_pwdata[15:0];
                    `IDX_QUEUE_FILTER_CONTROL: control_ff <= i_pwdata[4:0];
                    `IDX_IRQ_ENABLE: irq_enable_ff <= i_pwdata[1:0];
                    default: control_ff <= control_ff;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // multicast filter decision
    // ------------------------------------------------------------------
    // unicast frames and non-hash modes are passed here; other filters judge them
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_filter_valid <= 1'b0;
            o_filter_pass <= 1'b0;
        end else if (i_ce) begin
            o_filter_valid <= hash_valid;
            if (hash_valid) begin
                if (!da_multicast || !control_ff[`CTL_HASH_PERFECT_MODE]) begin
                    o_filter_pass <= 1'b1;
                // [RL12] bypass table
                end else if (control_ff[`CTL_ACCEPT_ALL_FRAMES] ||
                             control_ff[`CTL_ACCEPT_ALL_MULTICAST]) begin
                    o_filter_pass <= 1'b1;
                end else begin
                    // [RL9] word then bit; [RL10] set passes; [RL11] clear drops
                    o_filter_pass <= hash_bits_ff[hash_index[5:4]][hash_index[3:0]];
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/qtmh_asserts.sv
// port level checks for the queue threshold and multicast hash block
`default_nettype none
module qtmh_asserts (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_da_valid,
    input wire logic o_filter_valid,
    input wire logic o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------------
    // committed write: the only thing allowed to drop the irq line
    wire logic wr_done = i_psel && i_penable && i_pwrite && o_pready;
    pready_wait_a:
    assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("pready late");
    pready_pulse_a:
    assert property (o_pready |=> !o_pready) else $error("pready held");
    err_with_ready_a:
    assert property (o_pslverr |-> o_pready) else $error("stray pslverr");
    err_read_zero_a:
    assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0) else $error("refused read data");
    upper_zero_a:
    assert property (i_psel && o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0)
        else $error("upper half set");
    // ------------------------------------------------------------------
    // filter and interrupt
    // ------------------------------------------------------------------
    filter_timing_a:
    assert property (o_filter_valid |-> $past(i_da_valid, 2)) else $error("decision off time");
    filter_pulse_a:
    assert property (o_filter_valid |=> !o_filter_valid) else $error("decision held");
    irq_clear_a:
    assert property ($fell(o_irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("irq dropped alone");
    reset_quiet_a:
    assert property ($rose(i_nrst) |-> !o_irq && !o_pready && !o_filter_valid)
        else $error("outputs after reset");
endmodule
bind queue_threshold_and_multicast_hash qtmh_asserts qtmh_asserts_i (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_da_valid(i_da_valid), .o_filter_valid(o_filter_valid), .o_irq(o_irq));
`default_nettype wire

// ===== tb/rx_mac_model.sv
// receive mac stand-in: destination address bytes and queue events
`default_nettype none
module rx_mac_model (
    input wire logic i_clk,
    output logic o_da_valid,
    output logic o_da_first,
    output logic [7:0] o_da_byte,
    output logic o_frame_done,
    output logic o_frame_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle at time zero
    initial begin
        o_da_valid = 1'b0;
        o_da_first = 1'b0;
        o_da_byte = 8'h00;
        o_frame_done = 1'b0;
        o_frame_taken = 1'b0;
    end
    task automatic send_da(input logic [47:0] da);
        for (int b = 0; b < 6; b++) begin
            @(posedge i_clk);
            o_da_valid <= 1'b1;
            o_da_first <= (b == 0);
            o_da_byte <= da[8*b +: 8];
        end
        @(posedge i_clk);
        o_da_valid <= 1'b0;
        o_da_first <= 1'b0;
        // idle byte lane shows the inverse, so a stale copy never looks valid
        o_da_byte <= ~da[47:40];
    endtask
    // one-cycle frame entered or released
    task automatic rx_event(input logic take);
        @(posedge i_clk);
        o_frame_done <= !take;
        o_frame_taken <= take;
        @(posedge i_clk);
        o_frame_done <= 1'b0;
        o_frame_taken <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/queue_threshold_and_multicast_hash_tb_top.sv
// self-checking bench for the queue threshold and multicast hash block
`default_nettype none
module queue_threshold_and_multicast_hash_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_nrst, i_ce, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic o_filter_valid, o_filter_pass, o_irq, da_valid, da_first, rx_done, rx_taken;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rnd;
    logic [15:0] i_tx_free_dw, hv;
    logic [7:0] da_byte;
    logic [47:0] da;
    logic [5:0] idx;
    logic [32:0] rd_q[$], flt_q[$];
    int fails = 0, n_compared = 0;
    localparam logic [11:0] ADDRS [10] = '{12'h270, 12'h278, 12'h280, 12'h288, 12'h290,
        12'h298, 12'h200, 12'h204, 12'h208, 12'h20c};
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    queue_threshold_and_multicast_hash queue_threshold_and_multicast_hash_i (.i_clk(i_clk),
        .i_nrst(i_nrst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rx_frame_done(rx_done),
        .i_rx_frame_taken(rx_taken), .i_tx_free_dw(i_tx_free_dw), .i_da_valid(da_valid),
        .i_da_first(da_first), .i_da_byte(da_byte), .o_filter_valid(o_filter_valid),
        .o_filter_pass(o_filter_pass), .o_irq(o_irq));
    rx_mac_model rx_mac_model_i (.i_clk(i_clk), .o_da_valid(da_valid),
        .o_da_first(da_first), .o_da_byte(da_byte), .o_frame_done(rx_done),
        .o_frame_taken(rx_taken));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reference hash: lsb first, no final inversion
    function automatic logic [5:0] hash_idx(input logic [47:0] d);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04c11db7 : 32'h0);
        return c[31:26];
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one apb transfer; reads leave their expectation for the watcher
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] exp);
        int n;
        if (!w) rd_q.push_back(exp);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 20 && o_pready !== 1'b1; n++) @(posedge i_clk);
        if (n == 20) begin
            check(33'h1, 33'h0, "apb timeout");
            give_verdict();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge i_clk);
        check({32'h0, o_irq}, {32'h0, e}, "irq level");
    endtask
    // watcher: oldest note against each result as it appears
    always @(posedge i_clk) begin
        if (o_pready === 1'b1 && i_psel && !i_pwrite) begin
            if (rd_q.size() == 0) check(33'h1, 33'h0, "unexpected read");
            else check({o_pslverr, o_prdata}, rd_q.pop_front(), "read");
        end
        if (o_filter_valid === 1'b1) begin
            if (flt_q.size() == 0) check(33'h1, 33'h0, "unexpected decision");
            else check({32'h0, o_filter_pass}, flt_q.pop_front(), "filter");
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        i_tx_free_dw = 16'h0010;
        i_ce = 1'b1;
        rnd = 32'h8ebc4cec;
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        foreach (ADDRS[k]) rd(ADDRS[k], 32'h0);
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            wr(ADDRS[k], rnd);
            rd(ADDRS[k], k == 0 ? {24'h0, rnd[7:0]} : {16'h0, rnd[15:0]});
        end
        apb(1'b0, 12'h2fc, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 12'h272, 32'h0, {1'b1, 32'h0});
        wr(12'h2fc, 32'hffff);
        $display("test registers done");
        wr(12'h270, 32'h2);
        wr(12'h200, 32'h1);
        wr(12'h208, 32'h1);
        repeat (2) rx_mac_model_i.rx_event(1'b0);
        irq_is(1'b0);
        rx_mac_model_i.rx_event(1'b0);
        irq_is(1'b1);
        rd(12'h204, 32'h1);
        // count read before the next headers
        rd(12'h270, 32'h0302);
        wr(12'h20c, 32'h1);
        irq_is(1'b0);
        wr(12'h208, 32'h0);
        rx_mac_model_i.rx_event(1'b0);
        irq_is(1'b0);
        rd(12'h204, 32'h1);
        wr(12'h20c, 32'h1);
        repeat (4) rx_mac_model_i.rx_event(1'b1);
        wr(12'h200, 32'h0);
        wr(12'h208, 32'h1);
        rx_mac_model_i.rx_event(1'b0);
        irq_is(1'b1);
        rd(12'h270, 32'h0102);
        wr(12'h20c, 32'h1);
        $display("test receive done");
        wr(12'h278, 32'h40);
        wr(12'h200, 32'h2);
        wr(12'h208, 32'h2);
        irq_is(1'b0);
        i_tx_free_dw <= 16'h0040;
        irq_is(1'b1);
        rd(12'h204, 32'h2);
        wr(12'h20c, 32'h2);
        irq_is(1'b0);
        // clock enable low: a frame pulse must leave count and status alone
        i_ce <= 1'b0;
        rx_mac_model_i.rx_event(1'b0);
        i_ce <= 1'b1;
        rd(12'h204, 32'h0);
        rd(12'h270, 32'h0102);
        // enabled again, the same pulse is counted and caught
        rx_mac_model_i.rx_event(1'b0);
        rd(12'h270, 32'h0202);
        $display("test tx space done");
        // hit, miss, bypass, mode off, unicast
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(lfsr(rnd));
            da = {rnd[15:0], rnd};
            da[0] = (k != 11);
            idx = hash_idx(da);
            for (int w = 0; w < 4; w++) begin
                rnd = lfsr(rnd);
                hv = 16'h1 << idx[3:0];
                hv = (w != idx[5:4]) ? rnd[15:0] : ((k % 2 == 1 && k < 8) ? hv : ~hv);
                wr(12'h280 + 12'(8 * w), {16'h0, hv});
            end
            wr(12'h200, k == 8 ? 32'h0c : k == 9 ? 32'h14 : k == 10 ? 32'h0 : 32'h4);
            flt_q.push_back({32'h0, k >= 8 || k % 2 == 1});
            rx_mac_model_i.send_da(da);
            repeat (2) @(posedge i_clk);
        end
        $display("test hash filter done");
        for (int n = 0; n < 50 && rd_q.size() + flt_q.size() > 0; n++) @(posedge i_clk);
        if (rd_q.size() + flt_q.size() > 0) check(33'h1, 33'h0, "results missing");
        give_verdict();
    end
endmodule
`default_nettype wire
